//--- design/adc_regs_pkg.sv
// Shared constants and types for the converter status and control registers.
package adc_regs_pkg;

    // Base addresses of the two converter register instances.
    localparam logic [31:0] INST0_BASE     = 32'h4001_2400;
    localparam logic [31:0] INST1_BASE     = 32'h4001_2800;
    localparam int          NUM_INST       = 2;

    // Byte offsets inside one instance.
    localparam logic [3:0]  STATUS_OFS     = 4'h0;
    localparam logic [3:0]  CTL_A_OFS      = 4'h4;
    localparam logic [3:0]  CTL_B_OFS      = 4'h8;
    localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;

    // Status bit positions.
    localparam int          ST_WINDOW      = 0;
    localparam int          ST_DONE        = 1;
    localparam int          ST_STARTED     = 4;

    // Control register A fields and writable bits.
    localparam int          CA_ROUTINE_WIN = 23;
    localparam int          CA_PAIR_LSB    = 16;
    localparam int          CA_BURST_LSB   = 13;
    localparam int          CA_BURST_EN    = 11;
    localparam int          CA_WIN_SINGLE  = 9;
    localparam int          CA_SCAN        = 8;
    localparam int          CA_WIN_IRQ     = 6;
    localparam int          CA_DONE_IRQ    = 5;
    localparam int          CA_CHAN_LSB    = 0;
    localparam logic [31:0] CTL_A_MASK     = 32'h008f_eb7f;

    // Control register B fields and writable bits.
    localparam int          CB_POWER       = 0;
    localparam int          CB_CONT        = 1;
    localparam int          CB_CAL_START   = 2;
    localparam int          CB_CAL_RESET   = 3;
    localparam int          CB_DMA         = 8;
    localparam int          CB_ALIGN       = 11;
    localparam int          CB_TRIG_LSB    = 17;
    localparam int          CB_TRIG_EN     = 20;
    localparam int          CB_SW_START    = 22;
    localparam int          CB_TEMP_EN     = 23;
    localparam logic [31:0] CTL_B_MASK     = 32'h00de_090f;

    // Pair mode codes and the highest valid watchdog channel.
    localparam logic [3:0]  PAIR_INDEP     = 4'h0;
    localparam logic [3:0]  PAIR_PARALLEL  = 4'h6;
    localparam logic [3:0]  PAIR_FAST      = 4'h7;
    localparam logic [3:0]  PAIR_SLOW      = 4'h8;
    localparam logic [4:0]  MAX_WIN_CHAN   = 5'h11;

    typedef enum logic [1:0] {
        PM_INDEP    = 2'b00,
        PM_PARALLEL = 2'b01,
        PM_FAST     = 2'b10,
        PM_SLOW     = 2'b11
    } pair_mode_t;

    typedef struct packed {
        logic       conv_start;
        logic       conv_done;
        logic       data_read;
        logic       calib_reset_done;
        logic       calib_done;
    } core_evt_t;

    typedef struct packed {
        logic        valid;
        logic [4:0]  chan;
        logic [11:0] value;
    } result_t;

    typedef struct packed {
        logic       power;
        logic       continuous;
        logic       scan;
        logic       burst_en;
        logic [3:0] burst_len;
        logic       dma;
        logic       calib_reset;
        logic       calib_start;
        logic       sw_start;
        logic       trig_en;
        logic [2:0] trig_sel;
        logic       align;
        logic       temp_en;
    } seq_cfg_t;

    typedef struct packed {
        logic       hit;
        logic       inst;
        logic [3:0] ofs;
    } dec_t;

endpackage

//--- design/adc_status_control_regs.sv
// Status and control registers for two converter instances.
//
// Summary of operation
// - Start flag sets when a routine sequence begins; software clears with 0.
// - Done flag sets when a routine sequence conversion completes.
// - Done flag clears on software zero write or on data register read.
// - Window flag sets on out-of-threshold result; only software zero clears.
// - Control A bit 23 enables the routine window watchdog.
// - Pair code 0000 independent, 0110 parallel, 0111 fast, 1000 slow.
// - Pair mode field only acts in the first instance.
// - Burst mode converts burst count plus one channels per trigger.
// - Control A bit 11 enables burst (discontinuous) operation.
// - Bit 9 limits watchdog to the selected channel; else all checked.
// - Control A bit 8 enables scan across the routine sequence.
// - Control A bit 6 enables interrupt from the window flag.
// - Control A bit 5 enables interrupt from the done flag.
// - Watchdog channel field selects channels 0 to 17; higher reserved.
// - Two identical instances at their own base, same offsets.
// - Continuous bit makes the sequencer restart conversions repeatedly.
// - Power bit rising powers up; rewriting one unchanged starts conversion.
// - Calibration reset set by software, cleared by hardware when done.
// - DMA bit enables conversion result DMA requests.
`timescale 1ns/1ns
`default_nettype none
module adc_status_control_regs
    import adc_regs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output wire logic [31:0] rdata,
    input  wire core_evt_t   core_evt             [2],
    input  wire result_t     result               [2],
    input  wire logic [11:0] window_low_threshold [2],
    input  wire logic [11:0] window_high_threshold[2],
    output wire seq_cfg_t    seq_cfg              [2],
    output wire logic [1:0]  irq,
    output wire logic [1:0]  conv_start_req,
    output wire logic [1:0]  power_up_req,
    output wire pair_mode_t  pair_mode_select
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    function automatic dec_t decode_addr(input logic [31:0] a);
        dec_t r;
        r     = '0;
        r.ofs = a[3:0];
        if (a[1:0] == 2'b00 && a[3:2] != 2'b11) begin
            if (a[31:4] == INST0_BASE[31:4]) begin
                r.hit  = 1'b1;
                r.inst = 1'b0;
            end else if (a[31:4] == INST1_BASE[31:4]) begin
                r.hit  = 1'b1;
                r.inst = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic pair_mode_t pair_decode(input logic [3:0] code);
        pair_mode_t m;
        case (code)
            PAIR_INDEP:    m = PM_INDEP;
            PAIR_PARALLEL: m = PM_PARALLEL;
            PAIR_FAST:     m = PM_FAST;
            PAIR_SLOW:     m = PM_SLOW;
            // Reserved codes fall back to independent operation.
            default:       m = PM_INDEP;
        endcase
        return m;
    endfunction

    dec_t        dec;
    logic [31:0] inst_rd [2];
    logic [31:0] ctl_a0_d;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    pair_mode_t  pair_d;
    pair_mode_t  pair_q;

    assign dec = decode_addr(addr);

    genvar i;
    generate
        for (i = 0; i < NUM_INST; i++) begin : gen_inst
            logic        sel;
            logic        wr_st;
            logic        wr_a;
            logic        wr_b;
            logic [31:0] ctl_a_d;
            logic [31:0] ctl_a_q;
            logic [31:0] ctl_b_d;
            logic [31:0] ctl_b_q;
            logic        started;
            logic        done;
            logic        window;
            logic        chan_ok;
            logic        win_hit;
            logic        start_d;
            logic        start_q;
            logic        pwr_d;
            logic        pwr_q;
            logic        irq_d;
            logic        irq_q;
            seq_cfg_t    cfg_d;
            seq_cfg_t    cfg_q;

            assign sel   = dec.hit && (dec.inst == 1'(i));
            assign wr_st = wr_en && sel && dec.ofs == STATUS_OFS;
            assign wr_a  = wr_en && sel && dec.ofs == CTL_A_OFS;
            assign wr_b  = wr_en && sel && dec.ofs == CTL_B_OFS;

            // Reserved channel codes never match a converted channel.
            assign chan_ok = !ctl_a_q[CA_WIN_SINGLE] ||
                (result[i].chan == ctl_a_q[CA_CHAN_LSB +: 5] &&
                 ctl_a_q[CA_CHAN_LSB +: 5] <= MAX_WIN_CHAN);
            assign win_hit = result[i].valid && ctl_a_q[CA_ROUTINE_WIN] &&
                chan_ok &&
                (result[i].value < window_low_threshold[i] ||
                 result[i].value > window_high_threshold[i]);

            sticky_flag u_started (
                .clk    (clk),
                .resetn (resetn),
                .set    (core_evt[i].conv_start),
                .clr    (wr_st && !wdata[ST_STARTED]),
                .flag   (started)
            );

            sticky_flag u_done (
                .clk    (clk),
                .resetn (resetn),
                .set    (core_evt[i].conv_done),
                .clr    ((wr_st && !wdata[ST_DONE]) ||
                         core_evt[i].data_read),
                .flag   (done)
            );

            sticky_flag u_window (
                .clk    (clk),
                .resetn (resetn),
                .set    (win_hit),
                .clr    (wr_st && !wdata[ST_WINDOW]),
                .flag   (window)
            );

            always_comb begin
                ctl_a_d = ctl_a_q;
                if (wr_a) begin
                    ctl_a_d = wdata & CTL_A_MASK;
                end
                // Hardware clears first so that a software set wins.
                ctl_b_d = ctl_b_q;
                if (core_evt[i].calib_reset_done) begin
                    ctl_b_d[CB_CAL_RESET] = 1'b0;
                end
                if (core_evt[i].calib_done) begin
                    ctl_b_d[CB_CAL_START] = 1'b0;
                end
                if (core_evt[i].conv_start) begin
                    ctl_b_d[CB_SW_START] = 1'b0;
                end
                if (wr_b) begin
                    ctl_b_d = wdata & CTL_B_MASK;
                end
                start_d = wr_b && ctl_b_q[CB_POWER] && wdata[CB_POWER] &&
                          ((wdata & CTL_B_MASK) == ctl_b_q);
                pwr_d   = wr_b && !ctl_b_q[CB_POWER] &&
                          wdata[CB_POWER];
                irq_d   = (window && ctl_a_q[CA_WIN_IRQ]) ||
                          (done && ctl_a_q[CA_DONE_IRQ]);
                cfg_d.power       = ctl_b_d[CB_POWER];
                cfg_d.continuous  = ctl_b_d[CB_CONT];
                cfg_d.scan        = ctl_a_d[CA_SCAN];
                cfg_d.burst_en    = ctl_a_d[CA_BURST_EN];
                cfg_d.burst_len   = {1'b0, ctl_a_d[CA_BURST_LSB +: 3]} +
                                    4'h1;
                cfg_d.dma         = ctl_b_d[CB_DMA];
                cfg_d.calib_reset = ctl_b_d[CB_CAL_RESET];
                cfg_d.calib_start = ctl_b_d[CB_CAL_START];
                cfg_d.sw_start    = ctl_b_d[CB_SW_START];
                cfg_d.trig_en     = ctl_b_d[CB_TRIG_EN];
                cfg_d.trig_sel    = ctl_b_d[CB_TRIG_LSB +: 3];
                cfg_d.align       = ctl_b_d[CB_ALIGN];
                cfg_d.temp_en     = ctl_b_d[CB_TEMP_EN];
            end

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    ctl_a_q <= RESET_VALUE;
                    ctl_b_q <= RESET_VALUE;
                    start_q <= 1'b0;
                    pwr_q   <= 1'b0;
                    irq_q   <= 1'b0;
                    cfg_q   <= '{burst_len: 4'h1, default: '0};
                end else begin
                    ctl_a_q <= ctl_a_d;
                    ctl_b_q <= ctl_b_d;
                    start_q <= start_d;
                    pwr_q   <= pwr_d;
                    irq_q   <= irq_d;
                    cfg_q   <= cfg_d;
                end
            end

            always_comb begin
                case (dec.ofs)
                    STATUS_OFS: begin
                        inst_rd[i] = RESET_VALUE;
                        inst_rd[i][ST_STARTED] = started;
                        inst_rd[i][ST_DONE]    = done;
                        inst_rd[i][ST_WINDOW]  = window;
                    end
                    CTL_A_OFS: inst_rd[i] = ctl_a_q;
                    CTL_B_OFS: inst_rd[i] = ctl_b_q;
                    default:   inst_rd[i] = RESET_VALUE;
                endcase
            end

            assign seq_cfg[i]        = cfg_q;
            assign irq[i]            = irq_q;
            assign conv_start_req[i] = start_q;
            assign power_up_req[i]   = pwr_q;

            sequence s_power_rewrite;
                wr_b && ctl_b_q[CB_POWER] && wdata[CB_POWER] &&
                ((wdata & CTL_B_MASK) == ctl_b_q);
            endsequence
            sequence s_start_pulse;
                start_q ##1 (!start_q || $past(wr_b));
            endsequence

            property p_rewrite_starts;
                s_power_rewrite |=> s_start_pulse;
            endproperty
            a_rewrite_starts: assert property (p_rewrite_starts)
                else $error("power rewrite did not start a conversion");

            property p_start_needs_power;
                start_q |-> $past(ctl_b_q[CB_POWER]) && ctl_b_q[CB_POWER];
            endproperty
            a_start_needs_power: assert property (p_start_needs_power)
                else $error("conversion start without power enabled");

            property p_done_read_clears;
                (done && core_evt[i].data_read && !core_evt[i].conv_done)
                |=> !done;
            endproperty
            a_done_read_clears: assert property (p_done_read_clears)
                else $error("data read left done flag set");

            property p_done_sets;
                core_evt[i].conv_done |=> done;
            endproperty
            a_done_sets: assert property (p_done_sets)
                else $error("done flag not set after completion");

            property p_window_off;
                (!ctl_a_q[CA_ROUTINE_WIN] && !window) |=> !window;
            endproperty
            a_window_off: assert property (p_window_off)
                else $error("watchdog fired while disabled");

            property p_burst_len;
                cfg_q.burst_len ==
                    {1'b0, ctl_a_q[CA_BURST_LSB +: 3]} + 4'h1;
            endproperty
            a_burst_len: assert property (p_burst_len)
                else $error("burst length is not count plus one");

            property p_calib_clear;
                (ctl_b_q[CB_CAL_RESET] && core_evt[i].calib_reset_done &&
                 !wr_b) |=> !ctl_b_q[CB_CAL_RESET];
            endproperty
            a_calib_clear: assert property (p_calib_clear)
                else $error("calibration reset not cleared by hardware");

            property p_irq_follows;
                (window && ctl_a_q[CA_WIN_IRQ]) ##1 (window &&
                 ctl_a_q[CA_WIN_IRQ]) |-> irq_q;
            endproperty
            a_irq_follows: assert property (p_irq_follows)
                else $error("interrupt missing for enabled window flag");
        end
    endgenerate

    assign ctl_a0_d = gen_inst[0].ctl_a_d;

    always_comb begin
        pair_d  = pair_decode(ctl_a0_d[CA_PAIR_LSB +: 4]);
        rdata_d = RESET_VALUE;
        if (rd_en && dec.hit) begin
            rdata_d = inst_rd[dec.inst];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pair_q  <= PM_INDEP;
            rdata_q <= RESET_VALUE;
        end else begin
            pair_q  <= pair_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata            = rdata_q;
    assign pair_mode_select = pair_q;

    property p_pair_decode;
        (gen_inst[0].wr_a &&
         wdata[CA_PAIR_LSB +: 4] == PAIR_PARALLEL) |=>
            pair_q == PM_PARALLEL;
    endproperty
    a_pair_decode: assert property (p_pair_decode)
        else $error("parallel pair code not decoded");

    property p_pair_second_ignored;
        (gen_inst[1].wr_a && !gen_inst[0].wr_a) |=> $stable(pair_q);
    endproperty
    a_pair_second_ignored: assert property (p_pair_second_ignored)
        else $error("second instance changed pair mode");

    property p_unmapped_reads_zero;
        (rd_en && !dec.hit) |=> rdata_q == RESET_VALUE;
    endproperty
    a_unmapped_reads_zero: assert property (p_unmapped_reads_zero)
        else $error("unmapped read returned nonzero data");
endmodule
`default_nettype wire

//--- design/sticky_flag.sv
// Event flag that hardware sets and software clears, set winning.
`timescale 1ns/1ns
`default_nettype none
module sticky_flag
    import adc_regs_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic set,
    input  wire logic clr,
    output var  logic flag
);
    logic flag_d;

    always_comb begin
        flag_d = set | (flag & ~clr);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag <= 1'b0;
        end else begin
            flag <= flag_d;
        end
    end

    property p_set_wins;
        @(posedge clk) disable iff (!resetn)
        set |=> flag;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("flag lost a set event");

    property p_clear_only_on_request;
        @(posedge clk) disable iff (!resetn)
        (flag && !clr) |=> flag;
    endproperty
    a_clear_only_on_request: assert property (p_clear_only_on_request)
        else $error("flag dropped without a clear");
endmodule
`default_nettype wire

//--- tb/conv_core_model.sv
// Behavioural model of the converter core behind one register instance.
`timescale 1ns/1ns
`default_nettype none
module conv_core_model
    import adc_regs_pkg::*;
#(
    parameter int CONV_CYCLES = 6
)
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        start_req,
    input  wire seq_cfg_t    cfg,
    input  wire logic        data_rd,
    input  wire logic [4:0]  smp_chan,
    input  wire logic [11:0] smp_value,
    output var  core_evt_t   evt,
    output var  result_t     res
);
    int cnt_q;

    // Result fields carry inverted junk outside the valid pulse.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 0;
            evt   <= '0;
            res   <= '0;
        end else begin
            evt.conv_start <= start_req;
            evt.conv_done  <= (cnt_q == 1);
            evt.data_read  <= data_rd;
            evt.calib_reset_done <= cfg.calib_reset &
                                    ~evt.calib_reset_done;
            evt.calib_done <= cfg.calib_start & ~evt.calib_done;
            res.valid <= (cnt_q == 1);
            res.chan  <= (cnt_q == 1) ? smp_chan : ~res.chan;
            res.value <= (cnt_q == 1) ? smp_value : ~res.value;
            cnt_q <= start_req ? CONV_CYCLES : ((cnt_q > 0) ? cnt_q - 1 : 0);
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking testbench for the converter status and control registers.
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import adc_regs_pkg::*;
;
    logic        clk = 1'b0;
    logic        resetn;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rdata;
    core_evt_t   evt [2];
    result_t     res [2];
    logic [11:0] lo_thr [2];
    logic [11:0] hi_thr [2];
    seq_cfg_t    cfg [2];
    logic [1:0]  irq;
    logic [1:0]  start_req;
    logic [1:0]  power_req;
    pair_mode_t  pair_mode;
    logic [1:0]  drd;
    logic [4:0]  s_chan [2];
    logic [11:0] s_val [2];
    int          error_cnt = 0;
    int          checks = 0;

    always #4 clk = ~clk;

    adc_status_control_regs dut_u (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .core_evt(evt),
        .result(res), .window_low_threshold(lo_thr),
        .window_high_threshold(hi_thr), .seq_cfg(cfg), .irq(irq),
        .conv_start_req(start_req), .power_up_req(power_req),
        .pair_mode_select(pair_mode));

    for (genvar g = 0; g < 2; g++) begin : g_core
        conv_core_model core_u (
            .clk(clk), .resetn(resetn), .start_req(start_req[g]),
            .cfg(cfg[g]), .data_rd(drd[g]), .smp_chan(s_chan[g]),
            .smp_value(s_val[g]), .evt(evt[g]), .res(res[g]));
    end

    function automatic logic [31:0] ra(input int i, input logic [3:0] ofs);
        return (i == 0 ? INST0_BASE : INST1_BASE) + {28'h0, ofs};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Word-wide write; returns just after the edge that took it.
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp,
                        input string msg);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp, msg);
    endtask

    // Starts a conversion by rewriting the power bit and waits for its end.
    task automatic fire(input int i);
        int n;
        wr(ra(i, CTL_B_OFS), 32'h1);
        chk(32'(start_req[i]), 32'h1, "start pulse");
        n = 0;
        while (evt[i].conv_done !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(32'(evt[i].conv_done), 32'h1, "conversion end");
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic conv(input int i, input logic [4:0] ch,
                        input logic [11:0] v, input logic [31:0] st,
                        input logic ir);
        s_chan[i] <= ch;
        s_val[i]  <= v;
        fire(i);
        chk(32'(irq[i]), 32'(ir), "irq level");
        rchk(ra(i, STATUS_OFS), st, "status");
        wr(ra(i, STATUS_OFS), 32'h0);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 2; i++) begin
            rchk(ra(i, STATUS_OFS), RESET_VALUE, "status reset");
            rchk(ra(i, CTL_A_OFS), RESET_VALUE, "ctl A reset");
            rchk(ra(i, CTL_B_OFS), RESET_VALUE, "ctl B reset");
        end
        wr(INST0_BASE + 32'hc, 32'hffff_ffff);
        rchk(INST0_BASE + 32'hc, 32'h0, "unmapped read");
        $display("reset test done");
    endtask

    task automatic t_ctl_a();
        for (int i = 0; i < 2; i++) begin
            wr(ra(i, CTL_A_OFS), 32'hffff_ffff);
            rchk(ra(i, CTL_A_OFS), CTL_A_MASK, "ctl A bits");
            chk(32'({cfg[i].scan, cfg[i].burst_en, cfg[i].burst_len}),
                32'h38, "scan burst");
            wr(ra(i, CTL_A_OFS), 32'h0000_2000);
            chk(32'({cfg[i].scan, cfg[i].burst_en, cfg[i].burst_len}),
                32'h02, "burst len");
            wr(ra(i, CTL_A_OFS), 32'h0);
        end
        $display("control A test done");
    endtask

    task automatic t_pair();
        logic [3:0] code [6] = '{PAIR_INDEP, PAIR_PARALLEL, PAIR_FAST,
                                 PAIR_SLOW, 4'h3, 4'hf};
        pair_mode_t exp [6] = '{PM_INDEP, PM_PARALLEL, PM_FAST, PM_SLOW,
                                PM_INDEP, PM_INDEP};
        for (int k = 0; k < 6; k++) begin
            wr(ra(0, CTL_A_OFS), {12'h0, code[k], 16'h0});
            chk(32'(pair_mode), 32'(exp[k]), "pair mode");
        end
        wr(ra(0, CTL_A_OFS), 32'h0);
        wr(ra(1, CTL_A_OFS), {12'h0, PAIR_FAST, 16'h0});
        chk(32'(pair_mode), 32'(PM_INDEP), "second pair");
        rchk(ra(1, CTL_A_OFS), 32'h0007_0000, "second ctl A");
        wr(ra(1, CTL_A_OFS), 32'h0);
        $display("pair mode test done");
    endtask

    task automatic t_conv(input int i);
        wr(ra(i, CTL_B_OFS), 32'h1);
        chk(32'(power_req[i]), 32'h1, "power-up pulse");
        wr(ra(i, CTL_A_OFS), 32'h20);
        fire(i);
        chk(32'(irq[i]), 32'h1, "done irq");
        rchk(ra(i, STATUS_OFS), 32'h12, "start and done");
        @(posedge clk);
        drd[i] <= 1'b1;
        @(posedge clk);
        drd[i] <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(32'(irq[i]), 32'h0, "irq drop");
        rchk(ra(i, STATUS_OFS), 32'h10, "done cleared by read");
        wr(ra(i, STATUS_OFS), 32'h1f);
        rchk(ra(i, STATUS_OFS), 32'h10, "write one kept");
        wr(ra(i, STATUS_OFS), 32'h0);
        rchk(ra(i, STATUS_OFS), 32'h0, "write zero");
        wr(ra(i, CTL_A_OFS), 32'h0);
        $display("conversion test done");
    endtask

    task automatic t_window();
        wr(ra(0, CTL_A_OFS), 32'h0080_0040);
        conv(0, 5'h3, 12'h900, 32'h13, 1'b1);
        conv(0, 5'h3, 12'h800, 32'h12, 1'b0);
        wr(ra(0, CTL_A_OFS), 32'h0080_0245);
        conv(0, 5'h3, 12'h900, 32'h12, 1'b0);
        conv(0, 5'h5, 12'h0ff, 32'h13, 1'b1);
        wr(ra(0, CTL_A_OFS), 32'h0080_0251);
        conv(0, 5'h11, 12'h900, 32'h13, 1'b1);
        wr(ra(0, CTL_A_OFS), 32'h0080_0252);
        conv(0, 5'h12, 12'h900, 32'h12, 1'b0);
        wr(ra(0, CTL_A_OFS), 32'h0000_0040);
        conv(0, 5'h3, 12'h900, 32'h12, 1'b0);
        wr(ra(0, CTL_A_OFS), 32'h0);
        $display("window test done");
    endtask

    task automatic t_ctl_b();
        wr(ra(1, CTL_B_OFS), 32'hffff_ffff);
        repeat (4) @(posedge clk);
        #1;
        chk(32'({cfg[1].continuous, cfg[1].dma, cfg[1].calib_reset,
                 cfg[1].calib_start}), 32'hc, "ctl B mirror");
        chk(32'(cfg[1]), 32'h0003_067f, "ctl B fields");
        rchk(ra(1, CTL_B_OFS), 32'h00de_0903, "calib cleared");
        wr(ra(1, CTL_B_OFS), 32'h0);
        $display("control B test done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        resetn = 1'b0;
        addr   = 32'h0;
        wdata  = 32'h0;
        wr_en  = 1'b0;
        rd_en  = 1'b0;
        drd    = 2'b00;
        s_chan = '{5'h0, 5'h0};
        s_val  = '{12'h0, 12'h0};
        lo_thr = '{12'h100, 12'h100};
        hi_thr = '{12'h800, 12'h800};
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_ctl_a();
        t_pair();
        t_conv(0);
        t_conv(1);
        t_window();
        t_ctl_b();
        complete_run();
    end
endmodule
`default_nettype wire
